// *** include/dram_4k_pkg.sv ***
`default_nettype none
package dram_4k_pkg;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned ROW_W     = 6;
  localparam int unsigned COL_W     = 6;
  localparam int unsigned WORDS     = 4096;
  localparam int unsigned ROWS      = 64;
  localparam logic        DIR_READ  = 1'b1;
  localparam logic        DIR_WRITE = 1'b0;
  localparam logic [11:0] ADDR_RST  = 12'h000;
  // refresh interval in microseconds and derived clock count (longest time, exact product of the two)
  localparam int unsigned REFRESH_US      = 2000;
  localparam int unsigned CLK_MHZ         = 20;
  localparam int unsigned REFRESH_CYCLES  = REFRESH_US * CLK_MHZ;
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_READ    = 3'b010,
    ST_WRITE   = 3'b100
  } cyc_state_t;
endpackage
`default_nettype wire

// *** hw/sync2.sv ***
`default_nettype none
module sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// *** hw/dram_4k_cell_array.sv ***
`default_nettype none
// Behaviour
// - reads, writes and read-modify-writes happen only while strobe is high.
// - strobe low: deselected standby, precharging, no read or write.
// - direction high selects read, low selects write.
// - data input ignored on read; data output disabled on write.
// - address captured into registers at start of each cycle.
// - data bit stored on write or read-modify-write, only while strobe high.
// - one shared data pin, direction follows direction input.
// - read zero sinks the pin; read one leaves it released.
// - stored data reads back non-inverted.
// - any cycle on a row refreshes all 64 cells of that row.
// - memory holds 4096 one-bit words.
// - address is one parallel 12-bit value on dedicated lines.
module dram_4k_cell_array #(
  parameter int unsigned REFRESH_LIMIT = dram_4k_pkg::REFRESH_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        cycle_strobe,
  input  wire logic        read_not_write,
  input  wire logic [11:0] cell_address_lines,
  input  wire logic        data_in,
  output var  logic        data_out,
  output var  logic        data_oe,
  output var  logic [63:0] row_decayed
);
  localparam int unsigned CNT_W = $clog2(REFRESH_LIMIT + 1);

  logic        strobe_s;
  logic        dir_s;
  logic [11:0] addr_s;
  logic        din_s;

  // pins come from outside the clock domain
  sync2 #(.WIDTH(15)) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({cycle_strobe, read_not_write, cell_address_lines, data_in}),
    .q   ({strobe_s, dir_s, addr_s, din_s})
  );

  typedef struct packed {
    dram_4k_pkg::cyc_state_t state;
    logic                    strobe_d;
    logic [11:0]             addr;
    logic                    dout;
    logic                    oe;
  } ctl_t;

  ctl_t ctl;
  ctl_t next_ctl;
  logic [0:0]       cells [dram_4k_pkg::WORDS];
  logic [CNT_W-1:0] age   [dram_4k_pkg::ROWS];
  logic [63:0]      decayed;
  logic             wr_en;
  logic             rise;

  assign rise = strobe_s && !ctl.strobe_d;

  always_comb begin
    next_ctl          = ctl;
    next_ctl.strobe_d = strobe_s;
    wr_en             = 1'b0;
    case (ctl.state)
      dram_4k_pkg::ST_STANDBY: begin
        next_ctl.oe = 1'b0;
        if (rise) begin
          next_ctl.addr = addr_s;
          next_ctl.state = (dir_s == dram_4k_pkg::DIR_READ) ?
                           dram_4k_pkg::ST_READ : dram_4k_pkg::ST_WRITE;
        end
      end
      dram_4k_pkg::ST_READ: begin
        if (!strobe_s) begin
          next_ctl.state = dram_4k_pkg::ST_STANDBY;
          next_ctl.oe    = 1'b0;
        end else if (dir_s == dram_4k_pkg::DIR_WRITE) begin
          // read-modify-write: direction drops mid-cycle
          next_ctl.state = dram_4k_pkg::ST_WRITE;
          next_ctl.oe    = 1'b0;
        end else begin
          next_ctl.dout = cells[ctl.addr][0];
          // open drain: only a zero is driven
          next_ctl.oe   = !cells[ctl.addr][0];
        end
      end
      dram_4k_pkg::ST_WRITE: begin
        next_ctl.oe = 1'b0;
        if (!strobe_s) begin
          next_ctl.state = dram_4k_pkg::ST_STANDBY;
        end else if (dir_s == dram_4k_pkg::DIR_WRITE) begin
          wr_en = 1'b1;
        end
      end
      default: begin
        next_ctl.state = dram_4k_pkg::ST_STANDBY;
        next_ctl.oe    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl.state    <= dram_4k_pkg::ST_STANDBY;
      ctl.strobe_d <= 1'b0;
      ctl.addr     <= dram_4k_pkg::ADDR_RST;
      ctl.dout     <= 1'b0;
      ctl.oe       <= 1'b0;
    end else if (ce) begin
      ctl <= next_ctl;
    end
  end

  // no reset on the array: dram contents are undefined at power-up anyway
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      cells[ctl.addr] <= din_s;
    end
  end

  // retention model: a row untouched for too long is flagged as lost,
  // which lets a bench catch a controller that starves refresh
  genvar r;
  generate
    for (r = 0; r < dram_4k_pkg::ROWS; r++) begin : g_row
      always_ff @(posedge clk) begin
        if (rst) begin
          age[r]     <= '0;
          decayed[r] <= 1'b0;
        end else if (ce) begin
          if (rise && addr_s[dram_4k_pkg::ROW_W-1:0] == 6'(r)) begin
            age[r] <= '0;
          end else if (age[r] != CNT_W'(REFRESH_LIMIT)) begin
            age[r] <= age[r] + CNT_W'(1);
          end else begin
            decayed[r] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      data_out    <= 1'b0;
      data_oe     <= 1'b0;
      row_decayed <= 64'h0000_0000_0000_0000;
    end else if (ce) begin
      data_out    <= next_ctl.dout;
      data_oe     <= next_ctl.oe;
      row_decayed <= decayed;
    end
  end
endmodule
`default_nettype wire

// *** verification/dram_4k_checker.sv ***
`default_nettype none
module dram_4k_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cycle_strobe,
  input wire logic        read_not_write,
  input wire logic        data_out,
  input wire logic        data_oe,
  input wire logic [63:0] row_decayed
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // five samples cover the two sync stages plus the state change
  sequence idle_seen; !cycle_strobe [*5]; endsequence
  sequence write_seen; !read_not_write [*5]; endsequence
  chk_oe_sinks_zero: assert property (data_oe |-> !data_out)
    else $error("pin sunk for a one");
  chk_standby_quiet: assert property (idle_seen |-> !data_oe)
    else $error("pin sunk in standby");
  chk_write_no_oe: assert property (write_seen |-> !data_oe)
    else $error("pin sunk in write");
  chk_decay_sticky: assert property ((row_decayed & $past(row_decayed)) == $past(row_decayed))
    else $error("decay flag cleared");
  chk_reset_clear: assert property (disable iff (1'b0) rst |=> !data_oe && row_decayed == 64'h0)
    else $error("reset left state");
  // three samples back: two sync stages plus the data_oe output register
  chk_oe_in_read: assert property (data_oe |-> $past(cycle_strobe, 3) && $past(read_not_write, 3))
    else $error("pin sunk outside a read");
endmodule
`default_nettype wire

// *** verification/dram_ctrl_model.sv ***
`default_nettype none
module dram_ctrl_model (
  input  wire logic        clk,
  input  wire logic        data_oe,
  output var  logic        cycle_strobe,
  output var  logic        read_not_write,
  output var  logic [11:0] addr,
  output wire logic        pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv = 1'b0;
  logic val = 1'b0;
  // pull-up wins when nobody sinks or drives
  assign pin = data_oe ? 1'b0 : (drv ? val : 1'b1);
  initial begin
    cycle_strobe = 1'b0;
    read_not_write = 1'b1;
    addr = 12'h000;
  end
  task automatic cyc(input logic [11:0] a, input logic rd, input logic d, output logic q);
    @(negedge clk);
    addr = a;
    read_not_write = rd;
    drv = !rd;
    val = d;
    repeat (4) @(negedge clk);
    cycle_strobe = 1'b1;
    repeat (4) @(negedge clk);
    addr = ~a;
    repeat (4) @(negedge clk);
    q = pin;
    cycle_strobe = 1'b0;
    repeat (4) @(negedge clk);
    drv = 1'b0;
    read_not_write = 1'b1;
  endtask
  // read first, then drop direction inside the same strobe to write back
  task automatic rmw(input logic [11:0] a, input logic d, output logic q);
    @(negedge clk);
    addr = a;
    read_not_write = 1'b1;
    repeat (4) @(negedge clk);
    cycle_strobe = 1'b1;
    repeat (8) @(negedge clk);
    q = pin;
    read_not_write = 1'b0;
    drv = 1'b1;
    val = d;
    repeat (8) @(negedge clk);
    cycle_strobe = 1'b0;
    repeat (4) @(negedge clk);
    drv = 1'b0;
    read_not_write = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t mismatch", $time); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned LIM = 3000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        cycle_strobe, read_not_write, pin, data_out, data_oe, q;
  logic [11:0] addr;
  logic [63:0] row_decayed;
  int          err_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  initial forever #25 clk = ~clk;
  dram_ctrl_model ctl (.clk(clk), .data_oe(data_oe), .cycle_strobe(cycle_strobe),
    .read_not_write(read_not_write), .addr(addr), .pin(pin));
  dram_4k_cell_array #(.REFRESH_LIMIT(LIM)) dut_u (.clk(clk), .rst(rst), .ce(ce),
    .cycle_strobe(cycle_strobe), .read_not_write(read_not_write),
    .cell_address_lines(addr), .data_in(pin), .data_out(data_out),
    .data_oe(data_oe), .row_decayed(row_decayed));
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // column bits left arbitrary, read cycles only
  task automatic refresh_rows;
    for (int r = 0; r < 64; r++) ctl.cyc({6'h2a, 6'(r)}, 1'b1, 1'b0, q);
    `CHK(row_decayed, 64'h0)
  endtask
  task automatic write_read;
    logic [11:0] a[4] = '{12'h000, 12'h040, 12'hfff, 12'h7bf};
    logic        d[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) ctl.cyc(a[i], 1'b0, d[i], q);
    for (int i = 0; i < 4; i++) begin
      ctl.cyc(a[i], 1'b1, ~d[i], q);
      `CHK(q, d[i])
    end
  endtask
  // 12'h040 holds 0 from write_read; a frozen write must not land
  task automatic rmw_and_freeze;
    ctl.rmw(12'h040, 1'b1, q);
    `CHK(q, 1'b0)
    ctl.cyc(12'h040, 1'b1, 1'b0, q);
    `CHK(q, 1'b1)
    @(negedge clk) ce = 1'b0;
    ctl.cyc(12'h040, 1'b0, 1'b0, q);
    @(negedge clk) ce = 1'b1;
    ctl.cyc(12'h040, 1'b1, 1'b0, q);
    `CHK(q, 1'b1)
  endtask
  task automatic decay;
    repeat (LIM + 100) @(negedge clk);
    `CHK(row_decayed, {64{1'b1}})
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    refresh_rows;
    write_read;
    rmw_and_freeze;
    decay;
    tally_and_finish;
  end
endmodule
bind dram_4k_cell_array dram_4k_checker chk_u (.clk(clk), .rst(rst),
  .cycle_strobe(cycle_strobe), .read_not_write(read_not_write),
  .data_out(data_out), .data_oe(data_oe), .row_decayed(row_decayed));
`default_nettype wire
